/* src/sdb_cfg.svh */
/*
  Constants for the four-bank synchronous DRAM core: command codes,
  address fields, register offsets, reset values and timing.
  Assumes a single 25 MHz pclk and an APB register port.
*/
// Summary of operation
// - All inputs but presetn sampled on rising clock only
// - Four banks, 4096 rows, 512 columns here
// - ACTIVE takes bank and twelve-bit row
// - READ/WRITE address gives starting column
// - Burst walks columns in programmed order
// - Burst length 1,2,4,8,page; terminate allowed
// - Auto precharge starts itself after burst
// - New column accepted every clock cycle
// - Other banks precharge while one bursts
// - Auto refresh and power-down are provided
// - Deselect ignores commands; bursts, mask continue
// - Precharge scope bit high closes all banks
// - Column from bits 8..0; bit 10 precharge
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH

`define SDB_CMD_LMR      4'h0
`define SDB_CMD_REF      4'h1
`define SDB_CMD_PRE      4'h2
`define SDB_CMD_ACT      4'h3
`define SDB_CMD_WR       4'h4
`define SDB_CMD_RD       4'h5
`define SDB_CMD_BST      4'h6

`define SDB_PSB          10
`define SDB_COL_MSB      8
`define SDB_COLS_LAST    9'h1FF
`define SDB_COL_ONE      9'h001
`define SDB_FULL_PAGE    3'h7
`define SDB_ILV_BIT      3

`define SDB_REG_MODE     12'h000
`define SDB_REG_STAT     12'h004
`define SDB_REG_REFC     12'h008
`define SDB_MODE_RST     4'h3

`define SDB_CLK_NS       40
`define SDB_TRP_NS       20
`define SDB_TRP_CYC      ((`SDB_TRP_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)

`define SDB_STORE_AW     8
`define SDB_STORE_N      256

`endif

/* src/sdb_pkg.sv */
/*
  Types shared by the DRAM core and its helpers.
  Assumes sdb_cfg.svh constants are used beside it.
*/
package sdb_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdb_cmd_s;

  typedef struct packed {
    logic       ileave;
    logic [2:0] burst_len;
  } sdb_mode_s;

  typedef enum logic [2:0] {
    SDB_IDLE = 3'h1,
    SDB_RD   = 3'h2,
    SDB_WR   = 3'h4
  } sdb_bst_e;

  typedef struct packed {
    logic                  en;
    logic [7:0]            idx;
    logic [1:0]            be;
    logic [15:0]           data;
  } sdb_wr_s;

endpackage : sdb_pkg

/* src/sdb_fifo2.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module sdb_fifo2 #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wp_reg  <= wp_reg ^ push;
      rp_reg  <= rp_reg ^ pop;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : sdb_fifo2

/* src/sdb_store.sv */
/*
  Flip-flop data array with byte enables and one read index.
  Assumes the core folds bank, row and column into the index.
*/
`timescale 1ns/1ps
`include "sdb_cfg.svh"
module sdb_store (
  input  wire logic                    pclk,
  input  wire sdb_pkg::sdb_wr_s        wr,
  input  wire logic [`SDB_STORE_AW-1:0] ridx,
  output logic [15:0]                  rdata
);
  logic [15:0] mem_reg [`SDB_STORE_N];

  assign rdata = mem_reg[ridx];

  generate
    for (genvar b = 0; b < 2; b++) begin : g_lane
      always_ff @(posedge pclk) begin
        if (wr.en && wr.be[b]) begin
          mem_reg[wr.idx][b*8 +: 8] <= wr.data[b*8 +: 8];
        end
      end
    end
  endgenerate
endmodule : sdb_store

/* src/sdb_core.sv */
/*
  Four-bank synchronous DRAM core, 16-bit data, with APB registers.
  Assumes the host memory controller keeps command order and timing.
*/
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sdb_cfg.svh"
module sdb_core (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             cke,
  input  wire sdb_pkg::sdb_cmd_s cmd,
  input  wire logic [1:0]       ba,
  input  wire logic [11:0]      addr,
  input  wire logic [1:0]       dqm,
  input  wire logic [15:0]      dq_in,
  output logic [15:0]           dq_out,
  output logic                  dq_oe_n
);
  sdb_pkg::sdb_mode_s mode_reg;
  sdb_pkg::sdb_bst_e  bst_reg;
  logic [3:0]         open_reg;
  logic [3:0]         pch_reg;
  logic [11:0]        row_reg [4];
  logic [1:0]         tmr_reg [4];
  logic [1:0]         bank_reg;
  logic [8:0]         scol_reg;
  logic [8:0]         cnt_reg;
  logic               ap_reg;
  logic [15:0]        refc_reg;
  logic               pd_reg;
  logic [1:0]         dqm_d1_reg;
  logic [1:0]         dqm_d2_reg;
  logic [31:0]        prdata_reg;
  logic               taken;
  logic               c_act;
  logic               c_rd;
  logic               c_wr;
  logic               c_pre;
  logic               c_ref;
  logic               c_bst;
  logic               c_lmr;
  logic               col_ok;
  logic [8:0]         last;
  logic               adv;
  logic               at_last;
  logic               ap_fire;
  logic [1:0]         ap_bank;
  logic [8:0]         cur_col;
  logic               rd_push;
  logic               rd_ready;
  logic               out_valid;
  logic [15:0]        rdata;
  logic [`SDB_STORE_AW-1:0] ridx;
  sdb_pkg::sdb_wr_s   wr;
  logic               apb_acc;
  logic               mapped;

  function automatic logic is_cmd(input sdb_pkg::sdb_cmd_s c, input logic [3:0] code);
    return ({c.ras_n, c.cas_n, c.we_n} == code[2:0]);
  endfunction : is_cmd

  function automatic logic [8:0] col_at(input logic [8:0] s, input logic [8:0] n,
                                         input logic [8:0] m, input logic ilv);
    logic [8:0] lo;
    lo = ilv ? (s ^ n) : (s + n);
    return (s & ~m) | (lo & m);
  endfunction : col_at

  function automatic logic [`SDB_STORE_AW-1:0] sidx(input logic [1:0] b,
                                                   input logic [11:0] r,
                                                   input logic [8:0] c);
    return {b, r[1:0], c[3:0]};
  endfunction : sidx

  // Deselect or clock held low masks every command
  assign taken = !cmd.cs_n && cke;
  assign c_act = taken && is_cmd(cmd, `SDB_CMD_ACT);
  assign c_rd  = taken && is_cmd(cmd, `SDB_CMD_RD);
  assign c_wr  = taken && is_cmd(cmd, `SDB_CMD_WR);
  assign c_pre = taken && is_cmd(cmd, `SDB_CMD_PRE);
  assign c_ref = taken && is_cmd(cmd, `SDB_CMD_REF);
  assign c_bst = taken && is_cmd(cmd, `SDB_CMD_BST);
  assign c_lmr = taken && is_cmd(cmd, `SDB_CMD_LMR);
  // Column access only to an opened bank
  assign col_ok = (c_rd || c_wr) && open_reg[ba];

  // Burst length decode; full page wraps until terminated
  assign last = (mode_reg.burst_len == `SDB_FULL_PAGE) ? `SDB_COLS_LAST :
                ((`SDB_COL_ONE << mode_reg.burst_len) - `SDB_COL_ONE);
  assign at_last = (cnt_reg == last) && (mode_reg.burst_len != `SDB_FULL_PAGE);
  assign cur_col = col_at(scol_reg, cnt_reg, last, mode_reg.ileave);
  assign adv = cke && ((bst_reg == sdb_pkg::SDB_WR) ||
                       ((bst_reg == sdb_pkg::SDB_RD) && rd_ready));
  assign rd_push = cke && (bst_reg == sdb_pkg::SDB_RD);

  // Self-timed precharge when an auto-precharge burst ends
  always_comb begin
    ap_fire = 1'b0;
    ap_bank = bank_reg;
    if (col_ok && c_wr && (last == 9'h000) && addr[`SDB_PSB]) begin
      ap_fire = 1'b1;
      ap_bank = ba;
    end else if (adv && at_last && ap_reg && !col_ok && !c_bst) begin
      ap_fire = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_reg  <= sdb_pkg::SDB_IDLE;
      bank_reg <= 2'h0;
      scol_reg <= 9'h000;
      cnt_reg  <= 9'h000;
      ap_reg   <= 1'b0;
    end else if (col_ok) begin
      bank_reg <= ba;
      scol_reg <= addr[`SDB_COL_MSB:0];
      ap_reg   <= addr[`SDB_PSB];
      if (c_rd) begin
        bst_reg <= sdb_pkg::SDB_RD;
        cnt_reg <= 9'h000;
      end else begin
        bst_reg <= (last == 9'h000) ? sdb_pkg::SDB_IDLE : sdb_pkg::SDB_WR;
        cnt_reg <= `SDB_COL_ONE;
      end
    end else if (c_bst) begin
      bst_reg <= sdb_pkg::SDB_IDLE;
    end else if (adv) begin
      if (at_last) begin
        bst_reg <= sdb_pkg::SDB_IDLE;
      end else begin
        cnt_reg <= cnt_reg + `SDB_COL_ONE;
      end
    end
  end

  generate
    for (genvar b = 0; b < 4; b++) begin : g_bank
      logic start_pch;
      assign start_pch = (c_pre && (addr[`SDB_PSB] || (ba == b))) ||
                         (ap_fire && (ap_bank == b));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          open_reg[b] <= 1'b0;
          pch_reg[b]  <= 1'b0;
          tmr_reg[b]  <= 2'h0;
          row_reg[b]  <= 12'h000;
        end else if (start_pch) begin
          open_reg[b] <= 1'b0;
          pch_reg[b]  <= 1'b1;
          tmr_reg[b]  <= 2'(`SDB_TRP_CYC);
        end else if (c_act && (ba == b) && !open_reg[b] && !pch_reg[b]) begin
          open_reg[b] <= 1'b1;
          row_reg[b]  <= addr;
        end else if (pch_reg[b]) begin
          tmr_reg[b] <= tmr_reg[b] - 2'h1;
          pch_reg[b] <= (tmr_reg[b] != 2'h1);
        end
      end
    end
  endgenerate

  // Auto refresh counts only with every bank idle; power-down when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refc_reg <= 16'h0000;
      pd_reg   <= 1'b0;
    end else begin
      if (c_ref && (open_reg == 4'h0) && (pch_reg == 4'h0)) begin
        refc_reg <= refc_reg + 16'h0001;
      end
      pd_reg <= !cke && (bst_reg == sdb_pkg::SDB_IDLE);
    end
  end

  // Write data and mask taken with the command and each burst beat
  always_comb begin
    wr.en   = 1'b0;
    wr.be   = ~dqm;
    wr.data = dq_in;
    wr.idx  = sidx(bank_reg, row_reg[bank_reg], cur_col);
    if (col_ok && c_wr) begin
      wr.en  = 1'b1;
      wr.idx = sidx(ba, row_reg[ba], addr[`SDB_COL_MSB:0]);
    end else if (adv && (bst_reg == sdb_pkg::SDB_WR)) begin
      wr.en = 1'b1;
    end
  end

  assign ridx = sidx(bank_reg, row_reg[bank_reg], cur_col);

  sdb_store u_store (
    .pclk  (pclk),
    .wr    (wr),
    .ridx  (ridx),
    .rdata (rdata)
  );

  sdb_fifo2 #(.W(16)) u_rdbuf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rd_push),
    .in_ready  (rd_ready),
    .in_data   (rdata),
    .out_valid (out_valid),
    .out_ready (cke),
    .out_data  (dq_out)
  );

  // Read mask has two-clock latency onto the output enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dqm_d1_reg <= 2'h0;
      dqm_d2_reg <= 2'h0;
    end else begin
      dqm_d1_reg <= dqm;
      dqm_d2_reg <= dqm_d1_reg;
    end
  end
  assign dq_oe_n = !(out_valid && !(&dqm_d2_reg));

  // APB slave, zero wait states, read data prepared in setup
  assign apb_acc = psel && penable;
  assign mapped  = (paddr == `SDB_REG_MODE) || (paddr == `SDB_REG_STAT) ||
                   (paddr == `SDB_REG_REFC);
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !mapped;
  assign prdata  = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `SDB_MODE_RST;
    end else if (apb_acc && pwrite && (paddr == `SDB_REG_MODE)) begin
      mode_reg <= pwdata[3:0];
    end else if (c_lmr) begin
      mode_reg.ileave    <= addr[`SDB_ILV_BIT];
      mode_reg.burst_len <= addr[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `SDB_REG_MODE: prdata_reg <= {28'h0000000, mode_reg};
        `SDB_REG_STAT: prdata_reg <= {20'h00000, bst_reg, pd_reg, pch_reg, open_reg};
        `SDB_REG_REFC: prdata_reg <= {16'h0000, refc_reg};
        default:       prdata_reg <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_cmd;
    col_ok && c_rd && !c_pre;
  endsequence
  sequence s_burst_runs;
    bst_reg == sdb_pkg::SDB_RD;
  endsequence

  AST_DESELECT: assert property (
    cmd.cs_n && (bst_reg == sdb_pkg::SDB_IDLE) |=> (bst_reg == sdb_pkg::SDB_IDLE)
  ) else $error("deselected command started a burst");
  AST_ACT_ROW: assert property (
    c_act && !open_reg[ba] && !pch_reg[ba] && !c_pre |=>
      open_reg[$past(ba)] && (row_reg[$past(ba)] == $past(addr))
  ) else $error("active did not open the addressed row");
  AST_RD_COL: assert property (
    s_rd_cmd |=> s_burst_runs ##0 (scol_reg == $past(addr[`SDB_COL_MSB:0])) ##0
      (cnt_reg == 9'h000)
  ) else $error("read burst did not start at the given column");
  AST_BST_STOP: assert property (
    c_bst && !col_ok |=> (bst_reg == sdb_pkg::SDB_IDLE)
  ) else $error("terminate did not end the burst");
  AST_BURST_END: assert property (
    adv && at_last && !col_ok && !c_bst |=> (bst_reg == sdb_pkg::SDB_IDLE)
  ) else $error("burst ran past its length");
  AST_AP_START: assert property (
    ap_fire |=> pch_reg[$past(ap_bank)] && !open_reg[$past(ap_bank)]
  ) else $error("auto precharge did not start");
  AST_PRE_ALL: assert property (
    c_pre && addr[`SDB_PSB] |=> (open_reg == 4'h0) && (pch_reg == 4'hF)
  ) else $error("precharge all missed a bank");
  AST_PCH_DONE: assert property (
    $rose(pch_reg[0]) |-> ##[1:2] !pch_reg[0] || $rose(pch_reg[0])
  ) else $error("precharge timer did not expire");
  AST_REFRESH: assert property (
    c_ref && (open_reg == 4'h0) && (pch_reg == 4'h0) |=> refc_reg == $past(refc_reg) + 16'h0001
  ) else $error("refresh not counted");
endmodule : sdb_core

/* dv/sdb_host.sv */
/*
  Host controller model driving the DRAM command port.
  Assumes the bench calls its tasks in a legal command order.
*/
`timescale 1ns/1ps
module sdb_host (
  input  wire logic         pclk,
  output sdb_pkg::sdb_cmd_s cmd,
  output logic              cke,
  output logic [1:0]        ba,
  output logic [11:0]       addr,
  output logic [1:0]        dqm,
  output logic [15:0]       dq_in
);
  // No self refresh command exists here
  // Run is far shorter than the refresh period
  initial begin
    cmd   = sdb_pkg::sdb_cmd_s'(4'hF);
    cke   = 1'b1;
    ba    = 2'h0;
    addr  = 12'h000;
    dqm   = 2'h0;
    dq_in = 16'h0000;
  end
  // Change after an edge, hold one cycle
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d);
    cmd   <= sdb_pkg::sdb_cmd_s'(c);
    ba    <= b;
    addr  <= a;
    dq_in <= d;
    @(posedge pclk);
  endtask : issue
  // Idle data toggles so stale values never match
  task automatic nop();
    issue(4'h7, 2'h0, 12'h000, ~dq_in);
  endtask : nop
  task automatic set_cke(input logic v, input int n);
    cke <= v;
    repeat (n) @(posedge pclk);
  endtask : set_cke
  // Byte mask takes effect with the next command issued
  task automatic set_dqm(input logic [1:0] m);
    dqm <= m;
  endtask : set_dqm
endmodule : sdb_host

/* dv/tb.sv */
/*
  Self-checking bench for the DRAM core: registers, bursts, banks.
  Assumes sdb_host drives the command port.
*/
`timescale 1ns/1ps
`include "sdb_cfg.svh"
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (g), (e)); \
  end \
end
module tb;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cke;
  sdb_pkg::sdb_cmd_s cmd;
  logic [1:0]        ba;
  logic [11:0]       addr;
  logic [1:0]        dqm;
  logic [15:0]       dq_in;
  logic [15:0]       dq_out;
  logic              dq_oe_n;
  int                error_cnt;
  int                cmp_count;
  logic [31:0]       rdv;
  logic              err;
  logic              mon_oe_n;
  logic [15:0]       mon_dq;

  sdb_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cke, .cmd, .ba, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n);
  sdb_host u_host (.pclk, .cmd, .cke, .ba, .addr, .dqm, .dq_in);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Data outputs captured mid-cycle, where they have settled
  always @(negedge pclk) begin
    mon_oe_n <= dq_oe_n;
    mon_dq   <= dq_out;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e)
  endtask : rd_chk

  function automatic logic [8:0] col_of(input logic [8:0] s, input int i, input int len,
                                        input logic ilv);
    logic [8:0] m;
    m = 9'(len - 1);
    col_of = ilv ? (s ^ 9'(i)) : ((s & ~m) | ((s + 9'(i)) & m));
  endfunction : col_of

  task automatic wr_burst(input logic [1:0] b, input logic [11:0] a, input int len,
                          input logic ilv, input logic [15:0] base);
    for (int i = 0; i < len; i++) begin
      u_host.issue(i == 0 ? `SDB_CMD_WR : 4'h7, b, a,
                   base + {7'h0, col_of(a[8:0], i, len, ilv)});
    end
  endtask : wr_burst

  task automatic rd_burst(input logic [1:0] b, input logic [11:0] a, input int len,
                          input logic ilv, input logic [15:0] base, input logic stall,
                          input logic [3:0] sc, input logic [1:0] sb);
    int n;
    n = 0;
    u_host.issue(`SDB_CMD_RD, b, a, 16'h0000);
    u_host.issue(sc, sb, 12'h000, 16'h0000);
    for (int k = 0; k < 40 && n < len; k++) begin
      if (stall && k == 2) begin
        u_host.set_cke(1'b0, 3);
        u_host.set_cke(1'b1, 1);
      end else begin
        u_host.nop();
      end
      if (mon_oe_n === 1'b0) begin
        `CHK(mon_dq, base + {7'h0, col_of(a[8:0], n, len, ilv)})
        n++;
      end
    end
    `CHK(n, len)
    u_host.nop();
    `CHK(mon_oe_n, 1'b1)
  endtask : rd_burst

  task automatic t_regs();
    rd_chk(`SDB_REG_MODE, {28'h0, `SDB_MODE_RST});
    rd_chk(`SDB_REG_STAT, 32'h0000_0200);
    rd_chk(`SDB_REG_REFC, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, `SDB_REG_MODE, 32'h0000_0002);
    rd_chk(`SDB_REG_MODE, 32'h0000_0002);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wr_rd();
    u_host.issue(`SDB_CMD_ACT, 2'h0, 12'h005, 16'h0000);
    wr_burst(2'h0, 12'h402, 4, 1'b0, 16'hA000);
    u_host.nop();
    u_host.nop();
    rd_chk(`SDB_REG_STAT, 32'h0000_0200);
    u_host.issue(`SDB_CMD_ACT, 2'h0, 12'h005, 16'h0000);
    rd_burst(2'h0, 12'h400, 4, 1'b0, 16'hA000, 1'b0, 4'h7, 2'h0);
    u_host.nop();
    rd_chk(`SDB_REG_STAT, 32'h0000_0200);
    $display("test write read done");
  endtask : t_wr_rd

  task automatic t_ilv();
    u_host.issue(`SDB_CMD_LMR, 2'h0, 12'h00B, 16'h0000);
    u_host.nop();
    rd_chk(`SDB_REG_MODE, 32'h0000_000B);
    u_host.issue(`SDB_CMD_ACT, 2'h2, 12'h001, 16'h0000);
    wr_burst(2'h2, 12'h000, 8, 1'b1, 16'hC000);
    rd_burst(2'h2, 12'h005, 8, 1'b1, 16'hC000, 1'b1, 4'h7, 2'h0);
    $display("test interleave stall done");
  endtask : t_ilv

  task automatic t_lens();
    u_host.issue(`SDB_CMD_ACT, 2'h1, 12'h003, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      u_host.issue(`SDB_CMD_LMR, 2'h0, 12'(i), 16'h0000);
      rd_burst(2'h2, 12'h001, 1 << i, 1'b0, 16'hC000, 1'b0,
               i == 0 ? 4'hB : (i == 1 ? `SDB_CMD_PRE : 4'h7), i == 1 ? 2'h1 : 2'h3);
    end
    rd_chk(`SDB_REG_STAT, 32'h0000_0204);
    $display("test lengths done");
  endtask : t_lens

  task automatic t_page();
    int k;
    u_host.issue(`SDB_CMD_LMR, 2'h0, 12'h007, 16'h0000);
    u_host.issue(`SDB_CMD_RD, 2'h2, 12'h000, 16'h0000);
    u_host.nop();
    for (int i = 0; i < 12; i++) begin
      u_host.nop();
      `CHK(mon_oe_n, 1'b0)
      if (i < 8) `CHK(mon_dq, 16'hC000 + 16'(i))
    end
    u_host.issue(`SDB_CMD_BST, 2'h2, 12'h000, 16'h0000);
    k = 0;
    while (mon_oe_n !== 1'b1 && k < 4) begin
      u_host.nop();
      k++;
    end
    `CHK(mon_oe_n, 1'b1)
    $display("test full page done");
  endtask : t_page

  task automatic t_banks();
    u_host.issue(`SDB_CMD_ACT, 2'h0, 12'h000, 16'h0000);
    u_host.issue(`SDB_CMD_ACT, 2'h1, 12'h000, 16'h0000);
    u_host.issue(`SDB_CMD_ACT, 2'h3, 12'h000, 16'h0000);
    u_host.nop();
    rd_chk(`SDB_REG_STAT, 32'h0000_020F);
    u_host.issue(`SDB_CMD_PRE, 2'h1, 12'h000, 16'h0000);
    u_host.nop();
    u_host.nop();
    rd_chk(`SDB_REG_STAT, 32'h0000_020D);
    u_host.issue(`SDB_CMD_PRE, 2'h0, 12'h400, 16'h0000);
    u_host.nop();
    u_host.nop();
    rd_chk(`SDB_REG_STAT, 32'h0000_0200);
    u_host.issue(`SDB_CMD_REF, 2'h0, 12'h000, 16'h0000);
    u_host.nop();
    rd_chk(`SDB_REG_REFC, 32'h0000_0001);
    u_host.set_cke(1'b0, 2);
    rd_chk(`SDB_REG_STAT, 32'h0000_0300);
    u_host.set_cke(1'b1, 1);
    $display("test banks done");
  endtask : t_banks

  // Two-word read from bank 3 column 4; mask m blanks the first word
  task automatic rd_pair(input logic [1:0] m);
    u_host.set_dqm(m);
    u_host.issue(`SDB_CMD_RD, 2'h3, 12'h004, 16'h0000);
    u_host.set_dqm(2'h0);
    u_host.nop();
    u_host.nop();
    `CHK(mon_oe_n, &m)
    if (!(&m)) `CHK(mon_dq, 16'h7704)
    u_host.nop();
    `CHK({mon_oe_n, mon_dq}, {1'b0, 16'hE034})
  endtask : rd_pair

  task automatic t_mask();
    u_host.issue(`SDB_CMD_LMR, 2'h0, 12'h001, 16'h0000);
    u_host.issue(`SDB_CMD_ACT, 2'h3, 12'h002, 16'h0000);
    u_host.issue(`SDB_CMD_WR, 2'h3, 12'h004, 16'hE004);
    u_host.issue(4'h7, 2'h3, 12'h000, 16'hE005);
    u_host.set_dqm(2'h1);
    u_host.issue(`SDB_CMD_WR, 2'h3, 12'h004, 16'h77FF);
    u_host.set_dqm(2'h2);
    u_host.issue(4'hF, 2'h3, 12'h000, 16'h1234);
    rd_pair(2'h0);
    rd_pair(2'h3);
    $display("test mask done");
  endtask : t_mask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wr_rd();
    t_ilv();
    t_lens();
    t_page();
    t_banks();
    t_mask();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
